//--- cpu_decoder_defs.svh
`ifndef CPU_DECODER_DEFS_SVH
`define CPU_DECODER_DEFS_SVH

// ----------------------------------------------------------------------------
// opcode groups, top nibble of the word
// ----------------------------------------------------------------------------
`define GRP_ZERO      4'h0
`define GRP_N         4'h1
`define GRP_M         4'h2
`define GRP_NM        4'h3
`define GRP_MD        4'h4
`define GRP_ND4       4'h5
`define GRP_NMD_ST    4'h6
`define GRP_NMD_LD    4'h7
`define GRP_D         4'h8
`define GRP_D12       4'h9
`define GRP_ND8       4'ha
`define GRP_I         4'hb
`define GRP_NI        4'hc

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define FLD_OP        15:12
`define FLD_HI        11:8
`define FLD_MID       7:4
`define FLD_LO        3:0
`define FLD_D8        7:0
`define FLD_D12       11:0
`define FLD_ZERO_REST 11:4

// ----------------------------------------------------------------------------
// variant codes inside a group
// ----------------------------------------------------------------------------
`define VAR_N_DIRECT   4'h0
`define VAR_N_PREDEC   4'h1
`define VAR_M_DIRECT   4'h0
`define VAR_M_POSTINC  4'h1
`define VAR_M_JUMP     4'h2
`define VAR_M_PC_REG   4'h3
`define VAR_NM_DIRECT  4'h0
`define VAR_NM_IND     4'h1
`define VAR_NM_MAC     4'h2
`define VAR_NM_POSTINC 4'h3
`define VAR_NM_PREDEC  4'h4
`define VAR_NM_INDEXED 4'h5
`define VAR_DISP4      4'h0
`define VAR_D_GBR_LD   4'h0
`define VAR_D_GBR_ST   4'h1
`define VAR_D_PC_R0    4'h2
`define VAR_D_BRANCH   4'h3
`define VAR_I_GBR_IDX  4'h0
`define VAR_I_R0       4'h1
`define VAR_I_TRAP     4'h2

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_WORD      16'h0000
`define RST_ADDR      32'h0000_0000

`endif

//--- cpu_decoder_pkg.sv
package cpu_decoder_pkg;

  typedef enum logic [3:0] {
    fmt_zero    = 4'h0,
    fmt_n       = 4'h1,
    fmt_m       = 4'h2,
    fmt_nm      = 4'h3,
    fmt_md      = 4'h4,
    fmt_nd4     = 4'h5,
    fmt_nmd     = 4'h6,
    fmt_d       = 4'h7,
    fmt_d12     = 4'h8,
    fmt_nd8     = 4'h9,
    fmt_i       = 4'ha,
    fmt_ni      = 4'hb,
    fmt_illegal = 4'hf
  } format_type;

  typedef enum logic [3:0] {
    mode_none                  = 4'h0,
    mode_direct                = 4'h1,
    mode_indirect              = 4'h2,
    mode_postinc               = 4'h3,
    mode_predec                = 4'h4,
    mode_indexed               = 4'h5,
    mode_reg_disp              = 4'h6,
    mode_gbr_disp              = 4'h7,
    mode_gbr_indexed           = 4'h8,
    mode_pc_disp               = 4'h9,
    mode_pc_reg                = 4'ha,
    mode_pc_rel                = 4'hb,
    mode_imm                   = 4'hc,
    mode_ctrl                  = 4'hd,
    mode_accum                 = 4'he,
    mode_general_register_zero = 4'hf
  } mode_type;

  typedef enum logic [1:0] {
    ctrl_status_word_register   = 2'h0,
    ctrl_global_base_register   = 2'h1,
    ctrl_accumulator_high       = 2'h2,
    ctrl_accumulator_low        = 2'h3
  } ctrl_type;

  typedef enum logic [3:0] {
    ea_none     = 4'h0,
    ea_indexed  = 4'h1,
    ea_src_disp = 4'h2,
    ea_dst_disp = 4'h3,
    ea_gbr_disp = 4'h4,
    ea_gbr_idx  = 4'h5,
    ea_pc_disp  = 4'h6,
    ea_pc_br8   = 4'h7,
    ea_pc_br12  = 4'h8,
    ea_pc_reg   = 4'h9,
    ea_src_reg  = 4'ha
  } ea_type;

  typedef struct packed {
    format_type fmt;
    mode_type   src_mode;
    mode_type   dst_mode;
    logic [3:0] src_reg;
    logic [3:0] dst_reg;
    logic [3:0] aux_reg;
    ctrl_type   ctrl;
    logic [11:0] disp;
    logic [7:0] imm;
    logic       mac;
    logic       illegal;
    ea_type     ea_sel;
  } dec_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
    dec_type     dec;
    logic [31:0] addr;
  } state_type;

endpackage

//--- operand_address_unit.sv
`timescale 1ns/10ps
`include "cpu_decoder_defs.svh"

module operand_address_unit (
  input  wire cpu_decoder_pkg::ea_type ea_sel,                     // address form
  input  wire logic [11:0]             disp,                       // raw displacement field
  input  wire logic [31:0]             general_register_zero_value, // register zero contents
  input  wire logic [31:0]             src_value,                  // source register contents
  input  wire logic [31:0]             dst_value,                  // destination register contents
  input  wire logic [31:0]             global_base_register_value, // global base contents
  input  wire logic [31:0]             pc_value,                   // program counter reference
  output logic      [31:0]             addr                        // effective address
);

  // ----------------------------------------------------------------------------
  // effective address
  // ----------------------------------------------------------------------------
  // displacements are byte units; operand size scaling is left to execute
  always_comb begin
    case (ea_sel)
      cpu_decoder_pkg::ea_indexed:  addr = general_register_zero_value + dst_value;
      cpu_decoder_pkg::ea_src_disp: addr = src_value + {28'h0000000, disp[3:0]};
      cpu_decoder_pkg::ea_dst_disp: addr = dst_value + {28'h0000000, disp[3:0]};
      cpu_decoder_pkg::ea_gbr_disp: addr = global_base_register_value + {24'h000000, disp[7:0]};
      cpu_decoder_pkg::ea_gbr_idx:  addr = global_base_register_value + general_register_zero_value;
      cpu_decoder_pkg::ea_pc_disp:  addr = pc_value + {24'h000000, disp[7:0]};
      cpu_decoder_pkg::ea_pc_br8:   addr = pc_value + {{24{disp[7]}}, disp[7:0]};
      cpu_decoder_pkg::ea_pc_br12:  addr = pc_value + {{20{disp[11]}}, disp};
      cpu_decoder_pkg::ea_pc_reg:   addr = pc_value + src_value;
      cpu_decoder_pkg::ea_src_reg:  addr = src_value;
      default:                      addr = 32'h0000_0000;
    endcase
  end

endmodule

//--- cpu_operand_format_decoder.sv
// Operation
// - sixteen-bit word, opcode bits choose format
// - zero-operand: bits 15:4 opcode, bits 3:0 ignored, no fields
// - control register stored or loaded via register
// - multiply-accumulate: both post-increment sources, accumulators
// - indexed destination: register zero plus Rn
// - global base plus displacement, register zero
// - pc plus displacement delivered to register zero
`timescale 1ns/10ps
`include "cpu_decoder_defs.svh"

module cpu_operand_format_decoder (
  input  wire logic [0:0]  core_clk,                      // core clock
  input  wire logic        resetn,                        // async reset, active low
  input  wire logic        ce,                            // clock enable, freezes all state
  input  wire logic        instr_valid,                   // word present from fetch
  input  wire logic [15:0] instr_word,                    // instruction word
  input  wire logic [31:0] pc_value,                      // pc reference for this word
  input  wire logic [31:0] general_register_zero_value,   // register zero contents
  input  wire logic [31:0] src_value,                     // contents of register in bits 7:4 or 11:8
  input  wire logic [31:0] dst_value,                     // contents of register in bits 11:8 or 7:4
  input  wire logic [31:0] global_base_register_value,    // global base contents
  output logic             out_valid,                     // decoded word valid
  output logic [15:0]      out_word,                      // decoded word
  output cpu_decoder_pkg::format_type out_format,         // operand format
  output cpu_decoder_pkg::mode_type   src_mode,           // source addressing mode
  output cpu_decoder_pkg::mode_type   dst_mode,           // destination addressing mode
  output logic [3:0]       src_reg,                       // source register number
  output logic [3:0]       dst_reg,                       // destination register number
  output logic [3:0]       aux_reg,                       // second source register
  output cpu_decoder_pkg::ctrl_type   ctrl_select,        // control register selected
  output logic [11:0]      displacement,                  // raw displacement field
  output logic [7:0]       immediate,                     // immediate field
  output logic             mac_op,                        // multiply-accumulate pair
  output logic             illegal,                       // illegal instruction
  output logic [31:0]      address                        // effective address
);

  // ----------------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------------
  function automatic cpu_decoder_pkg::dec_type decode_word(input logic [15:0] w);
    cpu_decoder_pkg::dec_type d;
    logic [3:0] hi;
    logic [3:0] mid;
    logic [3:0] lo;
    d = '0;
    hi = w[`FLD_HI];
    mid = w[`FLD_MID];
    lo = w[`FLD_LO];
    d.src_mode = cpu_decoder_pkg::mode_none;
    d.dst_mode = cpu_decoder_pkg::mode_none;
    d.ea_sel = cpu_decoder_pkg::ea_none;
    case (w[`FLD_OP])
      `GRP_ZERO: begin
        d.fmt = cpu_decoder_pkg::fmt_zero;
        d.illegal = (w[`FLD_ZERO_REST] != 8'h00);
      end
      `GRP_N: begin
        d.fmt = cpu_decoder_pkg::fmt_n;
        d.src_mode = cpu_decoder_pkg::mode_ctrl;
        d.ctrl = cpu_decoder_pkg::ctrl_type'(mid[1:0]);
        d.dst_reg = hi;
        d.illegal = (mid[3:2] != 2'h0);
        if (lo == `VAR_N_DIRECT) begin
          d.dst_mode = cpu_decoder_pkg::mode_direct;
        end else if (lo == `VAR_N_PREDEC) begin
          d.dst_mode = cpu_decoder_pkg::mode_predec;
        end else begin
          d.illegal = 1'b1;
        end
      end
      `GRP_M: begin
        d.fmt = cpu_decoder_pkg::fmt_m;
        d.src_reg = hi;
        d.ctrl = cpu_decoder_pkg::ctrl_type'(mid[1:0]);
        if (lo == `VAR_M_DIRECT || lo == `VAR_M_POSTINC) begin
          d.src_mode = (lo == `VAR_M_DIRECT) ? cpu_decoder_pkg::mode_direct : cpu_decoder_pkg::mode_postinc;
          d.dst_mode = cpu_decoder_pkg::mode_ctrl;
          d.illegal = (mid[3:2] != 2'h0);
        end else if (lo == `VAR_M_JUMP) begin
          d.src_mode = cpu_decoder_pkg::mode_indirect;
          d.ea_sel = cpu_decoder_pkg::ea_src_reg;
        end else if (lo == `VAR_M_PC_REG) begin
          d.src_mode = cpu_decoder_pkg::mode_pc_reg;
          d.ea_sel = cpu_decoder_pkg::ea_pc_reg;
        end else begin
          d.illegal = 1'b1;
        end
      end
      `GRP_NM: begin
        d.fmt = cpu_decoder_pkg::fmt_nm;
        d.src_reg = mid;
        d.dst_reg = hi;
        d.src_mode = cpu_decoder_pkg::mode_direct;
        if (lo == `VAR_NM_DIRECT) begin
          d.dst_mode = cpu_decoder_pkg::mode_direct;
        end else if (lo == `VAR_NM_IND) begin
          d.dst_mode = cpu_decoder_pkg::mode_indirect;
        end else if (lo == `VAR_NM_MAC) begin
          // destination field is a second pointer; results land in the accumulators
          d.mac = 1'b1;
          d.src_mode = cpu_decoder_pkg::mode_postinc;
          d.aux_reg = hi;
          d.dst_reg = 4'h0;
          d.dst_mode = cpu_decoder_pkg::mode_accum;
        end else if (lo == `VAR_NM_POSTINC) begin
          d.src_mode = cpu_decoder_pkg::mode_postinc;
          d.dst_mode = cpu_decoder_pkg::mode_direct;
        end else if (lo == `VAR_NM_PREDEC) begin
          d.dst_mode = cpu_decoder_pkg::mode_predec;
        end else if (lo == `VAR_NM_INDEXED) begin
          d.dst_mode = cpu_decoder_pkg::mode_indexed;
          d.ea_sel = cpu_decoder_pkg::ea_indexed;
        end else begin
          d.illegal = 1'b1;
        end
      end
      `GRP_MD: begin
        d.fmt = cpu_decoder_pkg::fmt_md;
        d.src_reg = mid;
        d.disp = {8'h00, lo};
        d.src_mode = cpu_decoder_pkg::mode_reg_disp;
        d.dst_mode = cpu_decoder_pkg::mode_general_register_zero;
        d.ea_sel = cpu_decoder_pkg::ea_src_disp;
        d.illegal = (hi != `VAR_DISP4);
      end
      `GRP_ND4: begin
        d.fmt = cpu_decoder_pkg::fmt_nd4;
        d.dst_reg = mid;
        d.disp = {8'h00, lo};
        d.src_mode = cpu_decoder_pkg::mode_general_register_zero;
        d.dst_mode = cpu_decoder_pkg::mode_reg_disp;
        d.ea_sel = cpu_decoder_pkg::ea_dst_disp;
        d.illegal = (hi != `VAR_DISP4);
      end
      `GRP_NMD_ST, `GRP_NMD_LD: begin
        d.fmt = cpu_decoder_pkg::fmt_nmd;
        d.src_reg = mid;
        d.dst_reg = hi;
        d.disp = {8'h00, lo};
        if (w[`FLD_OP] == `GRP_NMD_ST) begin
          d.src_mode = cpu_decoder_pkg::mode_direct;
          d.dst_mode = cpu_decoder_pkg::mode_reg_disp;
          d.ea_sel = cpu_decoder_pkg::ea_dst_disp;
        end else begin
          d.src_mode = cpu_decoder_pkg::mode_reg_disp;
          d.dst_mode = cpu_decoder_pkg::mode_direct;
          d.ea_sel = cpu_decoder_pkg::ea_src_disp;
        end
      end
      `GRP_D: begin
        d.fmt = cpu_decoder_pkg::fmt_d;
        d.disp = {4'h0, w[`FLD_D8]};
        if (hi == `VAR_D_GBR_LD) begin
          d.src_mode = cpu_decoder_pkg::mode_gbr_disp;
          d.dst_mode = cpu_decoder_pkg::mode_general_register_zero;
          d.ea_sel = cpu_decoder_pkg::ea_gbr_disp;
        end else if (hi == `VAR_D_GBR_ST) begin
          d.src_mode = cpu_decoder_pkg::mode_general_register_zero;
          d.dst_mode = cpu_decoder_pkg::mode_gbr_disp;
          d.ea_sel = cpu_decoder_pkg::ea_gbr_disp;
        end else if (hi == `VAR_D_PC_R0) begin
          d.src_mode = cpu_decoder_pkg::mode_pc_disp;
          d.dst_mode = cpu_decoder_pkg::mode_general_register_zero;
          d.ea_sel = cpu_decoder_pkg::ea_pc_disp;
        end else if (hi == `VAR_D_BRANCH) begin
          d.src_mode = cpu_decoder_pkg::mode_pc_rel;
          d.ea_sel = cpu_decoder_pkg::ea_pc_br8;
        end else begin
          d.illegal = 1'b1;
        end
      end
      `GRP_D12: begin
        d.fmt = cpu_decoder_pkg::fmt_d12;
        d.disp = w[`FLD_D12];
        d.src_mode = cpu_decoder_pkg::mode_pc_rel;
        d.ea_sel = cpu_decoder_pkg::ea_pc_br12;
      end
      `GRP_ND8: begin
        d.fmt = cpu_decoder_pkg::fmt_nd8;
        d.dst_reg = hi;
        d.disp = {4'h0, w[`FLD_D8]};
        d.src_mode = cpu_decoder_pkg::mode_pc_disp;
        d.dst_mode = cpu_decoder_pkg::mode_direct;
        d.ea_sel = cpu_decoder_pkg::ea_pc_disp;
      end
      `GRP_I: begin
        d.fmt = cpu_decoder_pkg::fmt_i;
        d.imm = w[`FLD_D8];
        d.src_mode = cpu_decoder_pkg::mode_imm;
        if (hi == `VAR_I_GBR_IDX) begin
          d.dst_mode = cpu_decoder_pkg::mode_gbr_indexed;
          d.ea_sel = cpu_decoder_pkg::ea_gbr_idx;
        end else if (hi == `VAR_I_R0) begin
          d.dst_mode = cpu_decoder_pkg::mode_general_register_zero;
        end else if (hi != `VAR_I_TRAP) begin
          d.illegal = 1'b1;
        end
      end
      `GRP_NI: begin
        d.fmt = cpu_decoder_pkg::fmt_ni;
        d.dst_reg = hi;
        d.imm = w[`FLD_D8];
        d.src_mode = cpu_decoder_pkg::mode_imm;
        d.dst_mode = cpu_decoder_pkg::mode_direct;
      end
      default: begin
        d.illegal = 1'b1;
      end
    endcase
    // an illegal word carries no operands so execute cannot act on stale fields
    if (d.illegal) begin
      d = '0;
      d.illegal = 1'b1;
      d.fmt = cpu_decoder_pkg::fmt_illegal;
    end
    return d;
  endfunction

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  cpu_decoder_pkg::state_type state;
  cpu_decoder_pkg::state_type next_state;
  cpu_decoder_pkg::dec_type   dec;
  logic [31:0]                ea_addr;

  assign dec = decode_word(instr_word);

  operand_address_unit operand_address_unit_inst (
    .ea_sel                      (dec.ea_sel),
    .disp                        (dec.disp),
    .general_register_zero_value (general_register_zero_value),
    .src_value                   (src_value),
    .dst_value                   (dst_value),
    .global_base_register_value  (global_base_register_value),
    .pc_value                    (pc_value),
    .addr                        (ea_addr)
  );

  always_comb begin
    next_state = state;
    if (ce) begin
      next_state.valid = instr_valid;
      if (instr_valid) begin
        next_state.word = instr_word;
        next_state.dec = dec;
        next_state.addr = ea_addr;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
      state.word <= `RST_WORD;
      state.addr <= `RST_ADDR;
    end else begin
      state <= next_state;
    end
  end

  assign out_valid = state.valid;
  assign out_word = state.word;
  assign out_format = state.dec.fmt;
  assign src_mode = state.dec.src_mode;
  assign dst_mode = state.dec.dst_mode;
  assign src_reg = state.dec.src_reg;
  assign dst_reg = state.dec.dst_reg;
  assign aux_reg = state.dec.aux_reg;
  assign ctrl_select = state.dec.ctrl;
  assign displacement = state.dec.disp;
  assign immediate = state.dec.imm;
  assign mac_op = state.dec.mac;
  assign illegal = state.dec.illegal;
  assign address = state.addr;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  logic [31:0] exp_indexed;
  logic [31:0] exp_gbr;
  logic [31:0] exp_pc;
  assign exp_indexed = general_register_zero_value + dst_value;
  assign exp_gbr = global_base_register_value + {24'h000000, instr_word[7:0]};
  assign exp_pc = pc_value + {24'h000000, instr_word[7:0]};

  capture_word_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (ce && instr_valid) |=> (out_valid && out_word == $past(instr_word)))
    else $error("decoded word does not match the word taken");

  zero_fields_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (out_format == cpu_decoder_pkg::fmt_zero) |-> (src_mode == cpu_decoder_pkg::mode_none &&
      dst_mode == cpu_decoder_pkg::mode_none && displacement == 12'h000 && immediate == 8'h00))
    else $error("zero-operand word carries operand fields");

  ctrl_store_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (out_format == cpu_decoder_pkg::fmt_n) |-> (src_mode == cpu_decoder_pkg::mode_ctrl &&
      (dst_mode == cpu_decoder_pkg::mode_direct || dst_mode == cpu_decoder_pkg::mode_predec) &&
      dst_reg == out_word[11:8]))
    else $error("control store operands wrong");

  ctrl_load_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (dst_mode == cpu_decoder_pkg::mode_ctrl) |-> (out_format == cpu_decoder_pkg::fmt_m &&
      src_reg == out_word[11:8] &&
      (src_mode == cpu_decoder_pkg::mode_direct || src_mode == cpu_decoder_pkg::mode_postinc)))
    else $error("control load operands wrong");

  mac_pair_a: assert property (@(posedge core_clk) disable iff (!resetn)
    mac_op |-> (src_mode == cpu_decoder_pkg::mode_postinc && dst_mode == cpu_decoder_pkg::mode_accum &&
      aux_reg == out_word[11:8] && src_reg == out_word[7:4]))
    else $error("multiply-accumulate operands wrong");

  indexed_ea_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (ce && instr_valid && dec.ea_sel == cpu_decoder_pkg::ea_indexed) |=>
      (dst_mode == cpu_decoder_pkg::mode_indexed && address == $past(exp_indexed)))
    else $error("indexed address is not register zero plus Rn");

  gbr_disp_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (ce && instr_valid && instr_word[15:12] == `GRP_D && instr_word[11:9] == 3'h0) |=>
      (address == $past(exp_gbr) && (src_mode == cpu_decoder_pkg::mode_general_register_zero ||
       dst_mode == cpu_decoder_pkg::mode_general_register_zero)))
    else $error("global base displacement access wrong");

  pc_r0_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (ce && instr_valid && instr_word[15:12] == `GRP_D && instr_word[11:8] == `VAR_D_PC_R0) |=>
      (dst_mode == cpu_decoder_pkg::mode_general_register_zero && address == $past(exp_pc)))
    else $error("pc-relative address to register zero wrong");

  illegal_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (ce && instr_valid && instr_word[15:12] > `GRP_NI) |=>
      (illegal && out_format == cpu_decoder_pkg::fmt_illegal && src_mode == cpu_decoder_pkg::mode_none))
    else $error("unmatched opcode not flagged illegal");

endmodule

//--- fetch_operand_model.sv
`timescale 1ns/10ps
// --------------------------------------------------------------------------
// register file and fetch side model
// --------------------------------------------------------------------------
module fetch_operand_model (
  input  wire logic        instr_valid,                 // word offered this cycle
  input  wire logic [15:0] instr_word,                  // word offered
  output logic      [31:0] general_register_zero_value, // register zero contents
  output logic      [31:0] src_value,                   // source register contents
  output logic      [31:0] dst_value,                   // destination register contents
  output logic      [31:0] global_base_register_value   // global base contents
);
  logic [31:0] r0;
  logic [31:0] src;
  logic [31:0] dst;
  logic [31:0] global_base_register;
  always_comb begin
    r0  = 32'h0000_0300;
    global_base_register = 32'h0001_0000;
    src = 32'h4000_0000 | {24'h0, (instr_word[15:12] == 4'h2) ? instr_word[11:8] : instr_word[7:4], 4'h0};
    dst = 32'h4000_0000 | {24'h0, (instr_word[15:12] == 4'h5) ? instr_word[7:4] : instr_word[11:8], 4'h0};
    // operands are not held outside a valid word, so show the inverse
    general_register_zero_value = instr_valid ? r0 : ~r0;
    global_base_register_value  = instr_valid ? global_base_register : ~global_base_register;
    src_value                   = instr_valid ? src : ~src;
    dst_value                   = instr_valid ? dst : ~dst;
  end
endmodule

//--- cpu_operand_format_decoder_tb.sv
`timescale 1ns/10ps
module cpu_operand_format_decoder_tb;
  // --------------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] w;
    logic [3:0]  f;
    logic [3:0]  s;
    logic [3:0]  d;
    logic [31:0] ad;
    logic [11:0] dp;
    logic [7:0]  im;
    logic [7:0]  rg;
    logic [1:0]  c;
  } row_type;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [31:0] pc_value = 32'h0000_8000;
  logic [31:0] general_register_zero_value, src_value, dst_value, global_base_register_value;
  logic out_valid, mac_op, illegal;
  logic [15:0] out_word;
  logic [3:0] src_reg, dst_reg, aux_reg;
  logic [11:0] displacement;
  logic [7:0] immediate;
  logic [31:0] address;
  cpu_decoder_pkg::format_type out_format;
  cpu_decoder_pkg::mode_type src_mode, dst_mode;
  cpu_decoder_pkg::ctrl_type ctrl_select;
  int err_total = 0;
  int compares = 0;
  row_type rows [0:30] = '{
    {16'h0000, 4'h0, 4'h0, 4'h0, 32'h0, 12'h0, 8'h0, 8'h00, 2'h0},
    {16'h1301, 4'h1, 4'hd, 4'h4, 32'h0, 12'h0, 8'h0, 8'h30, 2'h0},
    {16'h1330, 4'h1, 4'hd, 4'h1, 32'h0, 12'h0, 8'h0, 8'h30, 2'h3},
    {16'h2521, 4'h2, 4'h3, 4'hd, 32'h0, 12'h0, 8'h0, 8'h05, 2'h2},
    {16'h2510, 4'h2, 4'h1, 4'hd, 32'h0, 12'h0, 8'h0, 8'h05, 2'h1},
    {16'h3871, 4'h3, 4'h1, 4'h2, 32'h0, 12'h0, 8'h0, 8'h87, 2'h0},
    {16'h3465, 4'h3, 4'h1, 4'h5, 32'h4000_0340, 12'h0, 8'h0, 8'h46, 2'h0},
    {16'h8020, 4'h7, 4'h7, 4'hf, 32'h0001_0020, 12'h020, 8'h0, 8'h00, 2'h0},
    {16'h81f0, 4'h7, 4'hf, 4'h7, 32'h0001_00f0, 12'h0f0, 8'h0, 8'h00, 2'h0},
    {16'h8244, 4'h7, 4'h9, 4'hf, 32'h0000_8044, 12'h044, 8'h0, 8'h00, 2'h0},
    {16'hd000, 4'hf, 4'h0, 4'h0, 32'h0, 12'h0, 8'h0, 8'h00, 2'h0},
    {16'he123, 4'hf, 4'h0, 4'h0, 32'h0, 12'h0, 8'h0, 8'h00, 2'h0},
    {16'hf000, 4'hf, 4'h0, 4'h0, 32'h0, 12'h0, 8'h0, 8'h00, 2'h0},
    {16'h1051, 4'hf, 4'h0, 4'h0, 32'h0, 12'h0, 8'h0, 8'h00, 2'h0},
    {16'h0010, 4'hf, 4'h0, 4'h0, 32'h0, 12'h0, 8'h0, 8'h00, 2'h0},
    {16'h2602, 4'h2, 4'h2, 4'h0, 32'h4000_0060, 12'h0, 8'h0, 8'h06, 2'h0},
    {16'h2703, 4'h2, 4'ha, 4'h0, 32'h4000_8070, 12'h0, 8'h0, 8'h07, 2'h0},
    {16'h3a50, 4'h3, 4'h1, 4'h1, 32'h0, 12'h0, 8'h0, 8'ha5, 2'h0},
    {16'h3123, 4'h3, 4'h3, 4'h1, 32'h0, 12'h0, 8'h0, 8'h12, 2'h0},
    {16'h3214, 4'h3, 4'h1, 4'h4, 32'h0, 12'h0, 8'h0, 8'h21, 2'h0},
    {16'h4079, 4'h4, 4'h6, 4'hf, 32'h4000_0079, 12'h009, 8'h0, 8'h07, 2'h0},
    {16'h5035, 4'h5, 4'hf, 4'h6, 32'h4000_0035, 12'h005, 8'h0, 8'h30, 2'h0},
    {16'h6a28, 4'h6, 4'h1, 4'h6, 32'h4000_00a8, 12'h008, 8'h0, 8'ha2, 2'h0},
    {16'h7b4c, 4'h6, 4'h6, 4'h1, 32'h4000_004c, 12'h00c, 8'h0, 8'hb4, 2'h0},
    {16'h83f0, 4'h7, 4'hb, 4'h0, 32'h0000_7ff0, 12'h0f0, 8'h0, 8'h00, 2'h0},
    {16'h9801, 4'h8, 4'hb, 4'h0, 32'h0000_7801, 12'h801, 8'h0, 8'h00, 2'h0},
    {16'ha512, 4'h9, 4'h9, 4'h1, 32'h0000_8012, 12'h012, 8'h0, 8'h50, 2'h0},
    {16'hb0c3, 4'ha, 4'hc, 4'h8, 32'h0001_0300, 12'h0, 8'hc3, 8'h00, 2'h0},
    {16'hb155, 4'ha, 4'hc, 4'hf, 32'h0, 12'h0, 8'h55, 8'h00, 2'h0},
    {16'hb27e, 4'ha, 4'hc, 4'h0, 32'h0, 12'h0, 8'h7e, 8'h00, 2'h0},
    {16'hc96a, 4'hb, 4'hc, 4'h1, 32'h0, 12'h0, 8'h6a, 8'h90, 2'h0}
  };
  always #4 core_clk = ~core_clk;
  fetch_operand_model fetch_operand_model_inst (.instr_valid, .instr_word, .general_register_zero_value,
    .src_value, .dst_value, .global_base_register_value);
  cpu_operand_format_decoder cpu_operand_format_decoder_inst (.core_clk, .resetn, .ce, .instr_valid,
    .instr_word, .pc_value, .general_register_zero_value, .src_value, .dst_value, .global_base_register_value,
    .out_valid, .out_word, .out_format, .src_mode, .dst_mode, .src_reg, .dst_reg, .aux_reg, .ctrl_select,
    .displacement, .immediate, .mac_op, .illegal, .address);
  // --------------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // valid stays high so consecutive calls run back to back
  task automatic issue(input logic [15:0] w);
    @(negedge core_clk);
    instr_valid = 1'b1;
    instr_word  = w;
    @(negedge core_clk);
  endtask
  task automatic end_of_test();
    if (err_total == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (2) @(negedge core_clk);
    chk("reset valid", out_valid, 1'b0);
    resetn = 1'b1;
    foreach (rows[i]) begin
      issue(rows[i].w);
      chk("valid", out_valid, 1'b1);
      chk("word", out_word, rows[i].w);
      chk("format", out_format, rows[i].f);
      chk("src mode", src_mode, rows[i].s);
      chk("dst mode", dst_mode, rows[i].d);
      chk("illegal", illegal, rows[i].f == 4'hf);
      chk("address", address, rows[i].ad);
      chk("disp", displacement, rows[i].dp);
      chk("imm", immediate, rows[i].im);
      chk("regs", {dst_reg, src_reg}, rows[i].rg);
      chk("ctrl", ctrl_select, rows[i].c);
    end
    issue(16'h3462);
    chk("mac", mac_op, 1'b1);
    chk("mac src", src_reg, 4'h6);
    chk("mac aux", aux_reg, 4'h4);
    chk("mac src mode", src_mode, 4'h3);
    chk("mac dst mode", dst_mode, 4'he);
    chk("mac dst", dst_reg, 4'h0);
    // a held clock enable must swallow the offered word
    ce = 1'b0;
    instr_word = 16'h0000;
    @(negedge core_clk);
    chk("frozen word", out_word, 16'h3462);
    chk("frozen valid", out_valid, 1'b1);
    ce = 1'b1;
    instr_valid = 1'b0;
    @(negedge core_clk);
    chk("idle valid", out_valid, 1'b0);
    chk("kept word", out_word, 16'h3462);
    issue(16'h8020);
    resetn = 1'b0;
    #1;
    chk("reset address", address, 32'h0);
    chk("reset valid", out_valid, 1'b0);
    @(negedge core_clk);
    resetn = 1'b1;
    @(negedge core_clk);
    chk("word after reset", out_word, 16'h8020);
    end_of_test();
  end
endmodule
